// ---- cagw_regs.svh ----
// register indexes, field positions, reset values and timing counts of the gain writer
`ifndef CAGW_REGS_SVH
`define CAGW_REGS_SVH

`define CAGW_IDX_CTRL        5'h00
`define CAGW_IDX_CFG         5'h0F
`define CAGW_IDX_STAT        5'h10
`define CAGW_IDX_PROF0       5'h13
`define CAGW_IDX_PROF1       5'h17
`define CAGW_IDX_PROF2       5'h1B
`define CAGW_IDX_PROF3       5'h1F

`define CAGW_CTRL_SRST_BIT   5
`define CAGW_CFG_MODE_BIT    0
`define CAGW_CFG_PSEL_BIT    1
`define CAGW_CFG_POVR_BIT    2

`define CAGW_CTRL_RST        8'h00
`define CAGW_CFG_RST         8'h00
`define CAGW_PROF_RST        8'h00
`define CAGW_GAIN_LOWEST     8'h00

`define CAGW_MCLK_DIV        4
`define CAGW_DEBOUNCE_MCLK   56
`define CAGW_XFER_MAX_MCLK   200

`endif

// ---- cagw_pkg.sv ----
// types shared by the gain writer modules
package cagw_pkg;

  localparam int CAGW_AW = 8;

  typedef enum logic [1:0] {
    CAGW_OKAY   = 2'b00,
    CAGW_SLVERR = 2'b10
  } cagw_resp_t;

  typedef enum logic [1:0] {
    CAGW_SH_IDLE  = 2'b00,
    CAGW_SH_SETUP = 2'b01,
    CAGW_SH_HIGH  = 2'b10,
    CAGW_SH_DONE  = 2'b11
  } cagw_sh_state_t;

  typedef struct packed {
    logic               awvalid;
    logic [CAGW_AW-1:0] awaddr;
    logic               wvalid;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bready;
    logic               arvalid;
    logic [CAGW_AW-1:0] araddr;
    logic               rready;
  } cagw_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    cagw_resp_t  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    cagw_resp_t  rresp;
  } cagw_axi_rsp_t;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic load_strobe_n;
  } cagw_amp_t;

endpackage

// ---- cagw_shifter.sv ----
// three-wire serial shifter that sends one 8-bit gain word, msb first
`timescale 1ns/100ps
`include "cagw_regs.svh"
module cagw_shifter
  import cagw_pkg::*;
(
  input  wire logic       clk,      // system clock
  input  wire logic       reset_n,  // async reset, active low
  input  wire logic       clk_en,   // freezes state while low
  input  wire logic       tick,     // one master clock step
  input  wire logic       start,    // begin a word, taken on tick while idle
  input  wire logic [7:0] data,     // gain word to send
  output logic            busy,     // word in progress
  output cagw_amp_t       amp       // serial pins, registered
);

  cagw_sh_state_t state_ff;
  cagw_sh_state_t nxt_state;
  logic [7:0]     shreg_ff;
  logic [7:0]     nxt_shreg;
  logic [2:0]     bit_ff;
  logic [2:0]     nxt_bit;
  cagw_amp_t      amp_ff;
  cagw_amp_t      nxt_amp;

  // one bit takes two master cycles: data settles while sclk is low, then sclk rises
  always_comb begin
    nxt_state = state_ff;
    nxt_shreg = shreg_ff;
    nxt_bit   = bit_ff;
    nxt_amp   = amp_ff;
    if (tick) begin
      case (state_ff)
        CAGW_SH_IDLE: begin
          if (start) begin
            nxt_shreg             = data;
            nxt_bit               = 3'h0;
            nxt_amp.sdata         = data[7];
            nxt_amp.sclk          = 1'b0;
            nxt_amp.load_strobe_n = 1'b0;
            nxt_state             = CAGW_SH_SETUP;
          end
        end
        CAGW_SH_SETUP: begin
          nxt_amp.sclk = 1'b1;
          nxt_state    = CAGW_SH_HIGH;
        end
        CAGW_SH_HIGH: begin
          nxt_amp.sclk = 1'b0;
          // no exit other than finishing all eight bits
          if (bit_ff == 3'h7) begin
            nxt_state = CAGW_SH_DONE;
          end else begin
            nxt_bit       = bit_ff + 3'h1;
            nxt_shreg     = {shreg_ff[6:0], 1'b0};
            nxt_amp.sdata = shreg_ff[6];
            nxt_state     = CAGW_SH_SETUP;
          end
        end
        CAGW_SH_DONE: begin
          nxt_amp.load_strobe_n = 1'b1;
          nxt_amp.sdata         = 1'b0;
          nxt_state             = CAGW_SH_IDLE;
        end
        default: begin
          nxt_state = CAGW_SH_IDLE;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= CAGW_SH_IDLE;
      shreg_ff <= 8'h00;
      bit_ff   <= 3'h0;
      amp_ff   <= '{sclk: 1'b0, sdata: 1'b0, load_strobe_n: 1'b1};
    end else if (clk_en) begin
      state_ff <= nxt_state;
      shreg_ff <= nxt_shreg;
      bit_ff   <= nxt_bit;
      amp_ff   <= nxt_amp;
    end
  end

  assign busy = (state_ff != CAGW_SH_IDLE);
  assign amp  = amp_ff;

endmodule

// ---- cagw_top.sv ----
// gain writer for an external cable driver: axi4-lite registers, debounce and transfer control
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "cagw_regs.svh"
// What this block does
// - four 8-bit gain registers, one pair per mode
// - mode bit in 0x0F remaps profile registers
// - hardware reset zeroes gains, sends zero word
// - ctrl bit 5 soft reset clears gains, selection
// - soft reset sends zero only if nonzero
// - profile and gain change starts a write
// - word sent comes from active profile
// - active gain register write of a new value starts a transfer
// - wait 48-64 stable master cycles, strobe low
// - a started transfer always completes
// - whole transfer within 200 master cycles
// - soft reset clears cfg and gains, ctrl takes the written byte with bit 5 clear
// - reset assertion restores register defaults
// - master clock stops during reset
// - master clock is system clock over four
// - profile pin switches the active profile when cfg bit 2 is clear
module cagw_top
  import cagw_pkg::*;
#(
  parameter int MCLK_DIV      = `CAGW_MCLK_DIV,
  parameter int DEBOUNCE_MCLK = `CAGW_DEBOUNCE_MCLK
)(
  input  wire logic    clk,               // system clock, 20 MHz
  input  wire logic    reset_n,           // async reset, active low
  input  wire logic    clk_en,            // freezes all state while low
  input  cagw_axi_req_t axi_req,          // axi4-lite master to slave
  output cagw_axi_rsp_t axi_rsp,          // axi4-lite slave to master
  input  wire logic    profile_pin,       // transmit profile select pin
  output logic         amp_load_strobe_n, // load enable to cable driver, active low
  output logic         amp_sclk,          // serial clock to cable driver
  output logic         amp_sdata,         // serial data to cable driver
  output logic         aux_clock_out      // auxiliary clock, runs through reset
);

  // register index of a byte address: one aligned word per register
  function automatic logic [4:0] reg_index(input logic [CAGW_AW-1:0] addr);
    reg_index = addr[6:2];
  endfunction

  function automatic logic is_mapped(input logic [CAGW_AW-1:0] addr);
    logic [4:0] idx;
    idx = reg_index(addr);
    is_mapped = (addr[CAGW_AW-1] == 1'b0) &&
                (idx == `CAGW_IDX_CTRL  || idx == `CAGW_IDX_CFG   || idx == `CAGW_IDX_STAT ||
                 idx == `CAGW_IDX_PROF0 || idx == `CAGW_IDX_PROF1 ||
                 idx == `CAGW_IDX_PROF2 || idx == `CAGW_IDX_PROF3);
  endfunction

  // bus write side
  logic               aw_ok_ff;
  logic               nxt_aw_ok;
  logic               w_ok_ff;
  logic               nxt_w_ok;
  logic [CAGW_AW-1:0] waddr_ff;
  logic [CAGW_AW-1:0] nxt_waddr;
  logic [7:0]         wdata_ff;
  logic [7:0]         nxt_wdata;
  logic               wstrb0_ff;
  logic               nxt_wstrb0;
  logic               bvalid_ff;
  logic               nxt_bvalid;
  cagw_resp_t         bresp_ff;
  cagw_resp_t         nxt_bresp;
  logic               do_wr;
  // bus read side
  logic               rvalid_ff;
  logic               nxt_rvalid;
  logic [31:0]        rdata_ff;
  logic [31:0]        nxt_rdata;
  cagw_resp_t         rresp_ff;
  cagw_resp_t         nxt_rresp;
  // software registers
  logic [7:0]         ctrl_ff;
  logic [7:0]         nxt_ctrl;
  logic [7:0]         cfg_ff;
  logic [7:0]         nxt_cfg;
  logic [7:0]         prof_ff [4];
  logic [7:0]         nxt_prof [4];
  logic               soft_rst;
  // master clock and transfer control
  logic [2:0]         div_ff;
  logic [2:0]         nxt_div;
  logic               tick;
  logic [1:0]         sel_ff;
  logic [1:0]         nxt_sel;
  logic [7:0]         sent_ff;
  logic [7:0]         nxt_sent;
  logic [7:0]         hold_ff;
  logic [7:0]         nxt_hold;
  logic [6:0]         cnt_ff;
  logic [6:0]         nxt_cnt;
  logic               force_ff;
  logic               nxt_force;
  logic [7:0]         target;
  logic               pending;
  logic               start;
  logic               busy;
  cagw_amp_t          amp;

  // address and data are taken in either order; response only after both
  always_comb begin
    nxt_aw_ok  = aw_ok_ff;
    nxt_w_ok   = w_ok_ff;
    nxt_waddr  = waddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    do_wr      = aw_ok_ff && w_ok_ff && !bvalid_ff;
    if (axi_req.awvalid && axi_rsp.awready) begin
      nxt_aw_ok = 1'b1;
      nxt_waddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      nxt_w_ok   = 1'b1;
      nxt_wdata  = axi_req.wdata[7:0];
      nxt_wstrb0 = axi_req.wstrb[0];
    end
    if (bvalid_ff && axi_req.bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_wr) begin
      nxt_aw_ok  = 1'b0;
      nxt_w_ok   = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = is_mapped(waddr_ff) ? CAGW_OKAY : CAGW_SLVERR;
    end
  end

  // register writes; soft reset clears everything but the control register
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_cfg  = cfg_ff;
    nxt_prof = prof_ff;
    soft_rst = 1'b0;
    if (do_wr && wstrb0_ff) begin
      case (reg_index(waddr_ff))
        `CAGW_IDX_CTRL: begin
          nxt_ctrl = wdata_ff;
          nxt_ctrl[`CAGW_CTRL_SRST_BIT] = 1'b0;           // self-clearing trigger
          soft_rst = wdata_ff[`CAGW_CTRL_SRST_BIT];
        end
        `CAGW_IDX_CFG:   nxt_cfg     = wdata_ff;
        `CAGW_IDX_PROF0: nxt_prof[0] = wdata_ff;
        `CAGW_IDX_PROF1: nxt_prof[1] = wdata_ff;
        `CAGW_IDX_PROF2: nxt_prof[2] = wdata_ff;
        `CAGW_IDX_PROF3: nxt_prof[3] = wdata_ff;
        default: begin
        end
      endcase
    end
    if (soft_rst) begin
      nxt_cfg = `CAGW_CFG_RST;
      for (int i = 0; i < 4; i++) begin
        nxt_prof[i] = `CAGW_PROF_RST;
      end
    end
  end

  // read mux; data and response are registered
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rvalid_ff && axi_req.rready) begin
      nxt_rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = is_mapped(axi_req.araddr) ? CAGW_OKAY : CAGW_SLVERR;
      nxt_rdata  = 32'h0000_0000;
      if (is_mapped(axi_req.araddr)) begin
        case (reg_index(axi_req.araddr))
          `CAGW_IDX_CTRL:  nxt_rdata[7:0] = ctrl_ff;
          `CAGW_IDX_CFG:   nxt_rdata[7:0] = cfg_ff;
          `CAGW_IDX_STAT:  nxt_rdata[15:0] = {sent_ff, 4'h0, force_ff, sel_ff[0], pending, busy};
          `CAGW_IDX_PROF0: nxt_rdata[7:0] = prof_ff[0];
          `CAGW_IDX_PROF1: nxt_rdata[7:0] = prof_ff[1];
          `CAGW_IDX_PROF2: nxt_rdata[7:0] = prof_ff[2];
          `CAGW_IDX_PROF3: nxt_rdata[7:0] = prof_ff[3];
          default:         nxt_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // master clock as an enable, one cycle in MCLK_DIV; held at zero through reset
  assign tick = clk_en && (div_ff == 3'(MCLK_DIV - 1));
  assign nxt_div = tick ? 3'h0 : div_ff + 3'h1;

  // gain of the active profile; the mode bit picks which register pair holds the gains
  assign target  = prof_ff[sel_ff];
  assign pending = force_ff || (target != sent_ff);

  // debounce: the word must hold for DEBOUNCE_MCLK ticks before the strobe falls;
  // a change during a running word waits for it, trading latency for clean cycles
  always_comb begin
    nxt_sel   = sel_ff;
    nxt_sent  = sent_ff;
    nxt_hold  = hold_ff;
    nxt_cnt   = cnt_ff;
    nxt_force = force_ff;
    start     = 1'b0;
    if (tick) begin
      nxt_sel = {cfg_ff[`CAGW_CFG_MODE_BIT],
                 cfg_ff[`CAGW_CFG_POVR_BIT] ? cfg_ff[`CAGW_CFG_PSEL_BIT] : profile_pin};
      if (!pending) begin
        nxt_cnt  = 7'h00;
        nxt_hold = target;
      end else if (target != hold_ff) begin
        nxt_cnt  = 7'h00;
        nxt_hold = target;
      end else if (cnt_ff != 7'(DEBOUNCE_MCLK - 1)) begin
        nxt_cnt = cnt_ff + 7'h01;
      end else if (!busy) begin
        start     = 1'b1;
        nxt_sent  = hold_ff;
        nxt_force = 1'b0;
        nxt_cnt   = 7'h00;
      end
    end
  end

  // registers of the bus, the software state and the transfer control
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      waddr_ff  <= '0;
      wdata_ff  <= 8'h00;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= CAGW_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= CAGW_OKAY;
      ctrl_ff   <= `CAGW_CTRL_RST;
      cfg_ff    <= `CAGW_CFG_RST;
      for (int i = 0; i < 4; i++) begin
        prof_ff[i] <= `CAGW_PROF_RST;
      end
      div_ff    <= 3'h0;
      sel_ff    <= 2'h0;
      sent_ff   <= `CAGW_GAIN_LOWEST;
      hold_ff   <= `CAGW_GAIN_LOWEST;
      cnt_ff    <= 7'h00;
      force_ff  <= 1'b1;
    end else if (clk_en) begin
      aw_ok_ff  <= nxt_aw_ok;
      w_ok_ff   <= nxt_w_ok;
      waddr_ff  <= nxt_waddr;
      wdata_ff  <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
      ctrl_ff   <= nxt_ctrl;
      cfg_ff    <= nxt_cfg;
      prof_ff   <= nxt_prof;
      div_ff    <= nxt_div;
      sel_ff    <= nxt_sel;
      sent_ff   <= nxt_sent;
      hold_ff   <= nxt_hold;
      cnt_ff    <= nxt_cnt;
      force_ff  <= nxt_force;
    end
  end

  // write readies only while their own channel is empty and no write response waits; arready only while no read response waits
  assign axi_rsp.awready = !aw_ok_ff && !bvalid_ff;
  assign axi_rsp.wready  = !w_ok_ff && !bvalid_ff;
  assign axi_rsp.bvalid  = bvalid_ff;
  assign axi_rsp.bresp   = bresp_ff;
  assign axi_rsp.arready = !rvalid_ff;
  assign axi_rsp.rvalid  = rvalid_ff;
  assign axi_rsp.rdata   = rdata_ff;
  assign axi_rsp.rresp   = rresp_ff;

  cagw_shifter u_shifter (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .tick    (tick),
    .start   (start),
    .data    (hold_ff),
    .busy    (busy),
    .amp     (amp)
  );

  assign amp_load_strobe_n = amp.load_strobe_n;
  assign amp_sclk          = amp.sclk;
  assign amp_sdata         = amp.sdata;
  // buffered system clock; the only clock that keeps running in reset
  assign aux_clock_out     = clk;

endmodule

// ---- cagw_properties.sv ----
// assertions on the serial pins and clock of the gain writer
`timescale 1ns/100ps
module cagw_properties
  import cagw_pkg::*;
(
  input wire logic     clk,               // system clock
  input wire logic     reset_n,           // reset, active low
  input wire logic     clk_en,            // clock enable
  input cagw_axi_req_t axi_req,           // bus request
  input cagw_axi_rsp_t axi_rsp,           // bus response
  input wire logic     profile_pin,       // profile select
  input wire logic     amp_load_strobe_n, // load enable
  input wire logic     amp_sclk,          // serial clock
  input wire logic     amp_sdata,         // serial data
  input wire logic     aux_clock_out      // auxiliary clock
);
  logic [11:0] low_ff, nxt_low, high_ff, nxt_high;
  logic        bv_q_ff, pin_q_ff;

  // strobe low time; clocks since the last write response or pin change, saturating.
  // any write counts as a possible trigger, so this is stricter than the debounce itself
  always_comb begin
    nxt_low  = amp_load_strobe_n ? 12'h000 : low_ff + 12'h001;
    nxt_high = ((axi_rsp.bvalid && !bv_q_ff) || (profile_pin != pin_q_ff)) ? 12'h000 :
               high_ff + {11'h000, ~&high_ff};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_ff   <= 12'h000;
      high_ff  <= 12'h000;
      bv_q_ff  <= 1'b0;
      pin_q_ff <= 1'b0;
    end else begin
      low_ff   <= nxt_low;
      high_ff  <= nxt_high;
      bv_q_ff  <= axi_rsp.bvalid;
      pin_q_ff <= profile_pin;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // a started frame always lasts 17 master cycles
  strobe_len_a: assert property ($rose(amp_load_strobe_n) |-> low_ff == 12'h044)
    else $error("load frame length wrong");
  debounce_gap_a: assert property ($fell(amp_load_strobe_n) |-> high_ff >= 12'h0C0)
    else $error("frame started before debounce");
  sclk_framed_a: assert property (amp_sclk |-> !amp_load_strobe_n)
    else $error("serial clock outside frame");
  idle_low_a: assert property (amp_load_strobe_n |-> !amp_sclk && !amp_sdata)
    else $error("serial pins not idle low");
  // one master cycle is four system clocks
  sclk_width_a: assert property ($rose(amp_sclk) |-> amp_sclk [*4] ##1 !amp_sclk)
    else $error("serial clock pulse width wrong");
  sdata_hold_a: assert property (amp_sclk |-> $stable(amp_sdata))
    else $error("data moved while clock high");
  first_edge_a: assert property ($fell(amp_load_strobe_n) |-> !amp_sclk ##4 amp_sclk)
    else $error("first clock edge misplaced");
  aux_clock_a: assert property (@(negedge clk) aux_clock_out)
    else $error("aux clock not running");
endmodule

// ---- cagw_amp_model.sv ----
// behavioural cable driver: shifts in gain words from the serial pins
`timescale 1ns/100ps
module cagw_amp_model (
  input wire logic   amp_load_strobe_n, // load enable, active low
  input wire logic   amp_sclk,          // serial clock
  input wire logic   amp_sdata,         // serial data
  output logic [7:0] word,              // last word latched
  output logic [3:0] nbits,             // bits in last frame
  output int         words              // frames latched
);
  logic [7:0] shreg;
  logic [3:0] cnt;
  logic       open_f = 1'b0;

  initial words = 0;
  // frame opens on the falling load enable
  always @(negedge amp_load_strobe_n) begin
    cnt = 4'h0;
    open_f = 1'b1;
  end
  // bits taken on the rising serial clock, msb first
  always @(posedge amp_sclk) if (open_f) begin
    shreg = {shreg[6:0], amp_sdata};
    cnt = cnt + 4'h1;
  end
  // gain applied when the enable returns; a short frame shows in nbits
  always @(posedge amp_load_strobe_n) if (open_f) begin
    word = shreg;
    nbits = cnt;
    words = words + 1;
    open_f = 1'b0;
  end
endmodule

// ---- cagw_top_tb.sv ----
// self-checking bench for the gain writer
`timescale 1ns/100ps
`define CAGW_CHK(w, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %0h got %0h", w, e, g); end end
module cagw_top_tb;
  import cagw_pkg::*;
  logic          clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, pin = 1'b0;
  cagw_axi_req_t req = '0;
  cagw_axi_rsp_t rsp;
  logic          strb_n, sclk, sdata, aux;
  logic [7:0]    word;
  logic [3:0]    nbits;
  int            words, n_fail = 0, check_count = 0, cyc = 0;

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  cagw_top uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .axi_req(req), .axi_rsp(rsp),
    .profile_pin(pin), .amp_load_strobe_n(strb_n), .amp_sclk(sclk), .amp_sdata(sdata), .aux_clock_out(aux));
  cagw_amp_model amp (.amp_load_strobe_n(strb_n), .amp_sclk(sclk), .amp_sdata(sdata),
    .word(word), .nbits(nbits), .words(words));

  // bus write; each channel held until its own ready is seen at an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output cagw_resp_t r);
    logic aw, w;
    int n = 0;
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    while ((req.awvalid || req.wvalid) && n < 50) begin
      @(negedge clk);
      aw = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      @(posedge clk);
      n++;
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b1;
    do begin @(negedge clk); n++; end while (rsp.bvalid !== 1'b1 && n < 100);
    r = rsp.bresp;
    @(posedge clk);
    req.bready <= 1'b0;
    if (n >= 100) n_fail++;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input cagw_resp_t er);
    int n = 0;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin @(negedge clk); n++; end while (rsp.arready !== 1'b1 && n < 50);
    @(posedge clk);
    req.arvalid <= 1'b0;
    do begin @(negedge clk); n++; end while (rsp.rvalid !== 1'b1 && n < 100);
    `CAGW_CHK("read valid", 1'b1, rsp.rvalid)
    `CAGW_CHK("read data", e, rsp.rdata)
    `CAGW_CHK("read resp", er, rsp.rresp)
    @(posedge clk);
    req.rready <= 1'b0;
  endtask

  // waits bounded well past debounce plus frame
  task automatic expect_word(input logic [7:0] e);
    int w0 = words, n = 0;
    while (words == w0 && n < 2000) begin @(posedge clk); n++; end
    `CAGW_CHK("word arrived", w0 + 1, words)
    `CAGW_CHK("gain word", e, word)
    `CAGW_CHK("bit count", 4'h8, nbits)
  endtask

  task automatic quiet(input int n);
    int w0 = words;
    repeat (n) @(posedge clk);
    `CAGW_CHK("no transfer", w0, words)
  endtask

  task automatic wait_frame();
    int n = 0;
    while (strb_n !== 1'b0 && n < 2000) begin @(posedge clk); n++; end
  endtask

  task automatic t_reset();
    cagw_resp_t r;
    logic [7:0] a [6] = '{8'h00, 8'h3C, 8'h4C, 8'h5C, 8'h6C, 8'h7C};
    expect_word(8'h00);
    foreach (a[i]) rchk(a[i], 32'h0000_0000, CAGW_OKAY);
    rchk(8'h04, 32'h0000_0000, CAGW_SLVERR);
    wr(8'h04, 32'h0000_0001, r);
    `CAGW_CHK("unmapped write", CAGW_SLVERR, r)
    $display("test reset done");
  endtask

  task automatic t_gain();
    cagw_resp_t r;
    int t0;
    wr(8'h4C, 32'hFFFF_FFA5, r);
    t0 = cyc;
    wait_frame();
    `CAGW_CHK("debounce", 1'b1, cyc - t0 >= 188 && cyc - t0 <= 256)
    expect_word(8'hA5);
    `CAGW_CHK("transfer span", 1'b1, cyc - t0 <= 800)
    rchk(8'h4C, 32'h0000_00A5, CAGW_OKAY);
    rchk(8'h40, 32'h0000_A500, CAGW_OKAY);
    $display("test gain done");
  endtask

  task automatic t_profile();
    cagw_resp_t r;
    wr(8'h5C, 32'h0000_003C, r);
    quiet(400);
    pin <= 1'b1;
    expect_word(8'h3C);
    wr(8'h3C, 32'h0000_0004, r);
    expect_word(8'hA5);
    $display("test profile done");
  endtask

  // inactive pair loaded first, then mode switches to it
  task automatic t_mode();
    cagw_resp_t r;
    wr(8'h6C, 32'h0000_0081, r);
    wr(8'h7C, 32'h0000_007E, r);
    wr(8'h3C, 32'h0000_0005, r);
    expect_word(8'h81);
    wr(8'h3C, 32'h0000_0007, r);
    expect_word(8'h7E);
    $display("test mode done");
  endtask

  task automatic t_abort();
    cagw_resp_t r;
    wr(8'h7C, 32'h0000_0055, r);
    wait_frame();
    wr(8'h7C, 32'h0000_00AA, r);
    expect_word(8'h55);
    expect_word(8'hAA);
    $display("test abort done");
  endtask

  task automatic t_soft();
    cagw_resp_t r;
    wr(8'h00, 32'h0000_0021, r);
    expect_word(8'h00);
    rchk(8'h00, 32'h0000_0001, CAGW_OKAY);
    rchk(8'h3C, 32'h0000_0000, CAGW_OKAY);
    rchk(8'h7C, 32'h0000_0000, CAGW_OKAY);
    wr(8'h00, 32'h0000_0020, r);
    quiet(400);
    $display("test soft reset done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // reset held four clocks, 175 ns
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_gain();
    t_profile();
    t_mode();
    t_abort();
    t_soft();
    complete_run();
  end

  // watchdog at about three times the expected run
  initial begin
    repeat (12000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule

bind cagw_top cagw_properties chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .profile_pin(profile_pin), .amp_load_strobe_n(amp_load_strobe_n),
  .amp_sclk(amp_sclk), .amp_sdata(amp_sdata), .aux_clock_out(aux_clock_out));
